// *** core/opdec_map.svh ***
/*
  Offsets, field positions, reset values and fixed figures of the operand
  address decoder. Assumes APB byte addresses on an 8-bit paddr.
*/
`ifndef OPDEC_MAP_SVH
`define OPDEC_MAP_SVH

// Register byte offsets
`define OPDEC_CTRL_OFS 8'h00
`define OPDEC_STATUS_OFS 8'h04
`define OPDEC_INSTR_OFS 8'h08
`define OPDEC_SRC_OFS 8'h0c
`define OPDEC_PURE_OFS 8'h10
`define OPDEC_DEST_OFS 8'h14
`define OPDEC_VECTOR_OFS 8'h18
// General registers R0..R7 at 8'h20 + 4*n
`define OPDEC_GPR_TAG 3'h1

// Control bits
`define OPDEC_CTRL_RUN 0
`define OPDEC_CTRL_TRACE 1
`define OPDEC_CTRL_IRQ 2
`define OPDEC_CTRL_REEVAL 3
`define OPDEC_CTRL_RESET 3'h0

// Status bits
`define OPDEC_ST_BOUNDARY 0
`define OPDEC_ST_STACK 1
`define OPDEC_ST_TRACED 2
`define OPDEC_ST_BUSY 8

// Instruction fields
`define OPDEC_SF_HI 11
`define OPDEC_SF_LO 6
`define OPDEC_DR_HI 2
`define OPDEC_DR_LO 0

// Fixed figures
`define OPDEC_WORD_STEP 16'h0002
`define OPDEC_STACK_LIMIT 16'h0100
`define OPDEC_TRACE_VECTOR 16'h000c
`define OPDEC_PC_SEL 3'h7
`define OPDEC_SP_SEL 3'h6

`endif

// *** core/opdec_pkg.sv ***
/*
  Types and field helpers of the operand address decoder.
  Assumes opdec_map.svh is on the include path.
*/
`include "opdec_map.svh"

package opdec_pkg;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_LD_PC = 4'b0001,
    S_MEMRD = 4'b0010,
    S_GOT_INSTR = 4'b0011,
    S_RD_RS = 4'b0100,
    S_GOT_RS = 4'b0101,
    S_INDEX = 4'b0110,
    S_DEFER = 4'b0111,
    S_OPERAND = 4'b1000,
    S_FINISH = 4'b1001,
    S_DEST = 4'b1010,
    S_TRACE = 4'b1011,
    S_RE_GOT = 4'b1100,
    S_RE_DONE = 4'b1101
  } eng_state_t;

  function automatic logic [5:0] source_field(input logic [15:0] instr);
    source_field = instr[`OPDEC_SF_HI:`OPDEC_SF_LO];
  endfunction

  function automatic logic [2:0] source_mode(input logic [15:0] instr);
    logic [5:0] f;
    f = source_field(instr);
    source_mode = f[5:3];
  endfunction

  function automatic logic [2:0] source_reg_select(input logic [15:0] instr);
    logic [5:0] f;
    f = source_field(instr);
    source_reg_select = f[2:0];
  endfunction

  function automatic logic [2:0] dest_reg_select(input logic [15:0] instr);
    dest_reg_select = instr[`OPDEC_DR_HI:`OPDEC_DR_LO];
  endfunction

endpackage

// *** core/gpr_if.sv ***
/*
  Port between the decoder and its general register store.
  Assumes one read and one write per cycle, read data one cycle late.
*/
`timescale 1ns/100ps
`default_nettype none

interface gpr_if;
  logic [2:0] rd_addr;
  logic [15:0] rd_data;
  logic we;
  logic [2:0] wr_addr;
  logic [15:0] wr_data;

  modport owner (output rd_addr, output we, output wr_addr, output wr_data, input rd_data);
  modport store (input rd_addr, input we, input wr_addr, input wr_data, output rd_data);
endinterface

`default_nettype wire

// *** core/gpr_file.sv ***
/*
  Eight 16-bit general registers, R7 doubling as program counter.
  Assumes a single clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module gpr_file (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  gpr_if.store port
);
  logic [15:0] mem_reg [8];
  logic [15:0] rd_reg;

  // Read data is registered; a write lands before the next read samples it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        mem_reg[i] <= 16'h0000;
      end
      rd_reg <= 16'h0000;
    end else begin
      if (port.we) begin
        mem_reg[port.wr_addr] <= port.wr_data;
      end
      rd_reg <= mem_reg[port.rd_addr];
    end
  end

  assign port.rd_data = rd_reg;
endmodule // gpr_file

`default_nettype wire

// *** core/operand_address_decode.sv ***
/*
  Fetch and source-operand address engine of a 16-bit processor, with an
  APB register slave. Assumes word memory that answers mem_req with mem_ack
  and data in the same cycle, holding no request of its own.
*/
`timescale 1ns/100ps
`default_nettype none
`include "opdec_map.svh"

// Contract
// RL1: Source field is instruction bits 11:6; upper three mode, lower three register.
// RL2: Destination register is chosen straight from its field, no address calculation.
// RL3: Following-word fetch reads memory at PC then advances PC by 2.
// RL4: Mode 0 takes the selected register itself, no memory access, no side effect.
// RL5: Mode 2, not R7: read word at register, then increment register by 2.
// RL6: Mode 2 with R7: following word is immediate operand, PC moves past it.
// RL7: Mode 4: decrement register by 2 first, then read at decremented value.
// RL8: Mode 6, not R7: fetch following word, add register, read at sum.
// RL9: Mode 6 with R7: add following word to advanced PC, read there.
// RL10: Mode 1 reads via register; mode 3 reads pointer there, then increments by 2.
// RL11: Mode 3 with R7: following word is absolute operand address.
// RL12: Mode 5: decrement by 2, read pointer at register, then operand through it.
// RL13: Mode 7, not R7: read pointer at following word plus register, then operand.
// RL14: Mode 7 with R7: pointer at following word plus advanced PC, then operand.
// RL15: SP used in mode 4 or 5 and below octal 400 sets stack overflow.
// RL16: Running with no interrupt request: fetch at PC, add 2, then execute.
// RL17: After each instruction with trace set, change state via vector 14, clear trace. Code only records vector 0x000c, sets traced, clears trace.
// RL18: Side-effect-free re-evaluation repeats no updates; immediate reads at PC minus 2.
// RL19: Each increment, decrement and PC advance happens once per reference, in order.
// RL20: Odd word address does not complete; it sets the boundary error flag.
module operand_address_decode
  import opdec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Word memory port
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  gpr_if rf ();

  gpr_file u_gpr (
    .clk(clk),
    .resetn(resetn),
    .port(rf.store)
  );

  eng_state_t state_reg, state_next, ret_reg, ret_next;
  logic [15:0] pc_reg, pc_next, rs_reg, rs_next, addr_reg, addr_next;
  logic [15:0] data_reg, data_next, instr_reg, instr_next;
  logic [15:0] operand_reg, operand_next, pure_reg, pure_next;
  logic [15:0] dest_reg, dest_next, vector_reg, vector_next;
  logic [2:0] ctrl_reg, ctrl_next, flags_reg, flags_next;
  logic req_reg, req_next, inc_reg, inc_next;
  logic [2:0] eng_rd_addr, eng_wr_addr, mode, sel;
  logic eng_we;
  logic [15:0] eng_wr_data;

  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next, gwait_reg, gwait_next;
  logic ctrl_wr, reeval_go, apb_we, apb_gpr_req, apb_use;
  logic [2:0] flags_clr, apb_rd_addr;
  logic [15:0] base;

  assign mode = source_mode(instr_reg); // RL1
  assign sel = source_reg_select(instr_reg); // RL1
  assign apb_gpr_req = psel && (paddr[7:5] == `OPDEC_GPR_TAG);
  assign apb_use = apb_gpr_req && (state_reg == S_IDLE);

  // One register store port, the bus wins only while the engine is idle
  assign rf.rd_addr = apb_use ? apb_rd_addr : eng_rd_addr;
  assign rf.we = apb_use ? apb_we : eng_we;
  assign rf.wr_addr = apb_use ? paddr[4:2] : eng_wr_addr;
  assign rf.wr_data = apb_use ? pwdata[15:0] : eng_wr_data;

  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    pc_next = pc_reg;
    rs_next = rs_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    instr_next = instr_reg;
    operand_next = operand_reg;
    pure_next = pure_reg;
    dest_next = dest_reg;
    vector_next = vector_reg;
    req_next = req_reg;
    inc_next = inc_reg;
    flags_next = flags_reg & ~flags_clr;
    ctrl_next = ctrl_reg;
    eng_rd_addr = 3'h0;
    eng_we = 1'b0;
    eng_wr_addr = sel;
    eng_wr_data = 16'h0000;
    base = 16'h0000;
    unique case (state_reg)
      S_IDLE: begin
        if (reeval_go && !apb_gpr_req) begin
          eng_rd_addr = sel;
          state_next = S_RE_GOT;
        end else if (ctrl_reg[`OPDEC_CTRL_RUN] && !ctrl_reg[`OPDEC_CTRL_IRQ]
                     && !apb_gpr_req) begin // RL16
          eng_rd_addr = `OPDEC_PC_SEL;
          state_next = S_LD_PC;
        end
      end
      S_LD_PC: begin
        pc_next = rf.rd_data;
        addr_next = rf.rd_data;
        ret_next = S_GOT_INSTR;
        state_next = S_MEMRD;
      end
      S_MEMRD: begin
        if (addr_reg[0]) begin
          // Odd word address aborts the instruction before its memory cycle is requested
          flags_next[`OPDEC_ST_BOUNDARY] = 1'b1; // RL20
          inc_next = 1'b0;
          state_next = S_IDLE;
        end else if (!req_reg) begin
          req_next = 1'b1;
        end else if (mem_ack) begin
          req_next = 1'b0;
          data_next = mem_rdata;
          state_next = ret_reg;
        end
      end
      S_GOT_INSTR: begin
        instr_next = data_reg;
        eng_we = 1'b1;
        eng_wr_addr = `OPDEC_PC_SEL;
        eng_wr_data = pc_reg + `OPDEC_WORD_STEP; // RL16
        pc_next = eng_wr_data;
        state_next = S_RD_RS;
      end
      S_RD_RS: begin
        eng_rd_addr = sel;
        state_next = S_GOT_RS;
      end
      S_GOT_RS: begin
        rs_next = rf.rd_data;
        addr_next = rf.rd_data;
        state_next = S_MEMRD;
        unique case (mode)
          3'h0: begin
            operand_next = rf.rd_data; // RL4
            state_next = S_FINISH;
          end
          3'h1: ret_next = S_OPERAND; // RL10
          3'h2: begin
            // With R7 the register is the PC, so this is the immediate word
            inc_next = 1'b1; // RL5 RL6
            ret_next = S_OPERAND;
          end
          3'h3: begin
            inc_next = 1'b1; // RL10 RL11
            ret_next = S_DEFER;
          end
          3'h4, 3'h5: begin
            eng_we = 1'b1;
            eng_wr_data = rf.rd_data - `OPDEC_WORD_STEP; // RL7 RL12
            rs_next = eng_wr_data;
            addr_next = eng_wr_data;
            if (sel == `OPDEC_PC_SEL) begin
              pc_next = eng_wr_data;
            end
            ret_next = (mode == 3'h4) ? S_OPERAND : S_DEFER;
          end
          3'h6, 3'h7: begin
            addr_next = pc_reg; // RL3
            ret_next = S_INDEX;
          end
        endcase
      end
      S_INDEX: begin
        eng_we = 1'b1;
        eng_wr_addr = `OPDEC_PC_SEL;
        eng_wr_data = pc_reg + `OPDEC_WORD_STEP; // RL3 RL19
        pc_next = eng_wr_data;
        base = (sel == `OPDEC_PC_SEL) ? eng_wr_data : rs_reg; // RL9 RL14
        addr_next = data_reg + base; // RL8 RL13
        ret_next = (mode == 3'h7) ? S_DEFER : S_OPERAND;
        state_next = S_MEMRD;
      end
      S_DEFER: begin
        addr_next = data_reg; // RL12 RL13 RL14
        ret_next = S_OPERAND;
        state_next = S_MEMRD;
      end
      S_OPERAND: begin
        operand_next = data_reg;
        if (inc_reg) begin
          // Increment only after the last reference through the register
          eng_we = 1'b1;
          eng_wr_data = rs_reg + `OPDEC_WORD_STEP; // RL5 RL10 RL19
          rs_next = eng_wr_data;
          if (sel == `OPDEC_PC_SEL) begin
            pc_next = eng_wr_data; // RL6 RL11
          end
          inc_next = 1'b0;
        end
        state_next = S_FINISH;
      end
      S_FINISH: begin
        if (sel == `OPDEC_SP_SEL && (mode == 3'h4 || mode == 3'h5)
            && rs_reg < `OPDEC_STACK_LIMIT) begin
          flags_next[`OPDEC_ST_STACK] = 1'b1; // RL15
        end
        eng_rd_addr = dest_reg_select(instr_reg); // RL2
        state_next = S_DEST;
      end
      S_DEST: begin
        dest_next = rf.rd_data; // RL2
        state_next = S_TRACE;
      end
      S_TRACE: begin
        if (ctrl_reg[`OPDEC_CTRL_TRACE]) begin
          flags_next[`OPDEC_ST_TRACED] = 1'b1; // RL17
          vector_next = `OPDEC_TRACE_VECTOR; // RL17
          ctrl_next[`OPDEC_CTRL_TRACE] = 1'b0; // RL17
        end
        state_next = S_IDLE;
      end
      S_RE_GOT: begin
        // No register write on this path, so no register update is repeated
        state_next = S_IDLE;
        if (mode == 3'h0) begin
          pure_next = rf.rd_data; // RL18
        end else if (mode == 3'h1) begin
          addr_next = rf.rd_data;
          ret_next = S_RE_DONE;
          state_next = S_MEMRD;
        end else if (mode == 3'h2 && sel == `OPDEC_PC_SEL) begin
          addr_next = rf.rd_data - `OPDEC_WORD_STEP; // RL18
          ret_next = S_RE_DONE;
          state_next = S_MEMRD;
        end else begin
          pure_next = operand_reg; // RL18
        end
      end
      S_RE_DONE: begin
        pure_next = data_reg; // RL18
        state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
    // Software writes land after the engine, so a set by software is kept
    if (ctrl_wr) begin
      ctrl_next = pwdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      pc_reg <= 16'h0000;
      rs_reg <= 16'h0000;
      addr_reg <= 16'h0000;
      data_reg <= 16'h0000;
      instr_reg <= 16'h0000;
      operand_reg <= 16'h0000;
      pure_reg <= 16'h0000;
      dest_reg <= 16'h0000;
      vector_reg <= 16'h0000;
      req_reg <= 1'b0;
      inc_reg <= 1'b0;
      flags_reg <= 3'h0;
      ctrl_reg <= `OPDEC_CTRL_RESET;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      pc_reg <= pc_next;
      rs_reg <= rs_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      instr_reg <= instr_next;
      operand_reg <= operand_next;
      pure_reg <= pure_next;
      dest_reg <= dest_next;
      vector_reg <= vector_next;
      req_reg <= req_next;
      inc_reg <= inc_next;
      flags_reg <= flags_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // APB slave: one wait state for plain registers and general register writes, two for general register reads
  always_comb begin
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    gwait_next = 1'b0;
    ctrl_wr = 1'b0;
    reeval_go = 1'b0;
    flags_clr = 3'h0;
    apb_we = 1'b0;
    apb_rd_addr = 3'h0;
    if (psel && penable && !pready_reg) begin
      if (paddr[7:5] == `OPDEC_GPR_TAG) begin
        if (gwait_reg) begin
          prdata_next = {16'h0000, rf.rd_data};
          pready_next = 1'b1;
        end else if (state_reg != S_IDLE) begin
          // Refused while the engine owns the register store
          pready_next = 1'b1;
          pslverr_next = 1'b1;
        end else if (pwrite) begin
          apb_we = 1'b1;
          pready_next = 1'b1;
        end else begin
          apb_rd_addr = paddr[4:2];
          gwait_next = 1'b1;
        end
      end else begin
        pready_next = 1'b1;
        prdata_next = 32'h0000_0000;
        unique case (paddr)
          `OPDEC_CTRL_OFS: begin
            ctrl_wr = pwrite;
            reeval_go = pwrite && pwdata[`OPDEC_CTRL_REEVAL];
            prdata_next = {29'h0000_0000, ctrl_reg};
          end
          `OPDEC_STATUS_OFS: begin
            flags_clr = pwrite ? pwdata[2:0] : 3'h0;
            prdata_next = {23'h00_0000, (state_reg != S_IDLE), 5'h00, flags_reg};
          end
          `OPDEC_INSTR_OFS: prdata_next = {16'h0000, instr_reg};
          `OPDEC_SRC_OFS: prdata_next = {16'h0000, operand_reg};
          `OPDEC_PURE_OFS: prdata_next = {16'h0000, pure_reg};
          `OPDEC_DEST_OFS: prdata_next = {16'h0000, dest_reg};
          `OPDEC_VECTOR_OFS: prdata_next = {16'h0000, vector_reg};
          default: pslverr_next = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      gwait_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      gwait_reg <= gwait_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_req = req_reg;
  assign mem_addr = addr_reg;
endmodule // operand_address_decode

`default_nettype wire

// *** bench/word_memory_model.sv ***
/*
  Word memory behind the decoder's memory port, with a settable answer delay.
  Assumes one clock and requests held until acknowledged.
*/
`timescale 1ns/100ps
`default_nettype none

module word_memory_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Memory port
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  // Answer delay in cycles
  input wire logic [1:0] lat
);
  logic [15:0] words [logic [15:0]];
  logic [15:0] last = 16'h0000;
  logic [1:0] wait_cnt = 2'h0;
  int reads = 0;

  initial mem_ack = 1'b0;
  initial mem_rdata = 16'hffff;

  // Unwritten words read as address plus 0x400, so pointer chains stay even
  function automatic logic [15:0] word_at(input logic [15:0] a);
    return words.exists(a) ? words[a] : a + 16'h0400;
  endfunction

  // Data lines show the inverse of the last word outside an answer
  always @(posedge clk) begin
    if (!resetn || !mem_req || mem_ack) begin
      mem_ack <= 1'b0;
      wait_cnt <= 2'h0;
      mem_rdata <= ~last;
    end else if (wait_cnt >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= word_at(mem_addr);
      last <= word_at(mem_addr);
      reads <= reads + 1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule // word_memory_model

`default_nettype wire

// *** bench/operand_address_decode_assertions.sv ***
/*
  Port checker of the operand address decoder.
  Assumes binding to operand_address_decode, one clock.
*/
`timescale 1ns/100ps
`default_nettype none

module operand_address_decode_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Memory
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_wait; mem_req && !mem_ack; endsequence
  sequence s_taken; mem_req && mem_ack; endsequence

  req_hold_a: assert property (s_wait |=> mem_req && $stable(mem_addr))
    else $error("memory request changed before answer");
  req_drop_a: assert property (s_taken |=> !mem_req)
    else $error("memory request not released after answer");
  addr_even_a: assert property (mem_req |-> !mem_addr[0])
    else $error("odd word address issued");
  apb_answer_a: assert property ($rose(penable) && psel |-> ##[1:2] pready)
    else $error("register access not answered in time");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  reset_idle_a: assert property (disable iff (1'b0) !resetn |=> !mem_req && !pready)
    else $error("outputs active after reset");
endmodule // operand_address_decode_assertions

bind operand_address_decode operand_address_decode_assertions i_chk (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
);

`default_nettype wire

// *** bench/operand_address_decode_tb.sv ***
/*
  Self-checking bench of the operand address decoder over APB.
  Assumes word_memory_model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none
`include "opdec_map.svh"

module operand_address_decode_tb
  import opdec_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mem_req;
  logic [15:0] mem_addr;
  logic [15:0] mem_rdata;
  logic mem_ack;
  logic [1:0] lat = 2'h0;
  logic [15:0] cur_ins = 16'h0;
  logic [31:0] q;
  logic e;
  int num_errors = 0;
  int cmp_count = 0;
  int extra[8] = '{0, 1, 1, 2, 1, 2, 2, 3};

  always #5 clk = ~clk;

  operand_address_decode i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  word_memory_model i_mem (.clk(clk), .resetn(resetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .lat(lat));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idle cycle before each setup keeps psel from being assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check("pready", 32'h1, {31'h0, pready});
    if (pready !== 1'b1)
      test_done();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [7:0] ga(input logic [2:0] n);
    return 8'h20 + {3'h0, n, 2'h0};
  endfunction

  function automatic logic [15:0] mw(input logic [15:0] a);
    if (a == 16'h0100)
      return cur_ins;
    if (a == 16'h0102)
      return 16'h0010;
    return a + 16'h0400;
  endfunction

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(`OPDEC_STATUS_OFS);
      n++;
    end while (q[8] !== 1'b0 && n < 50);
    if (q[8] !== 1'b0) begin
      check("busy", 32'h0, {31'h0, q[8]});
      test_done();
    end
  endtask

  // Instruction at 0x100, following word 0x0010 at 0x102, R2 as destination
  task automatic prep(input logic [2:0] m, input logic [2:0] r, input logic [15:0] rv);
    cur_ins = {4'h1, m, r, 6'h02};
    i_mem.words.delete();
    i_mem.words[16'h0100] = cur_ins;
    i_mem.words[16'h0102] = 16'h0010;
    wr(ga(3'h2), 32'h0000beef);
    wr(ga(3'h7), 32'h00000100);
    wr(ga(r), {16'h0, rv});
  endtask

  // Second write drops run so exactly one instruction executes
  task automatic go(input logic [31:0] ctl);
    wr(`OPDEC_CTRL_OFS, ctl);
    wr(`OPDEC_CTRL_OFS, ctl & 32'h2);
    wait_idle();
  endtask

  task automatic run_one(input logic [2:0] m, input logic [2:0] r, input logic [15:0] rv,
                         input logic [31:0] ctl);
    logic [15:0] pc, rr, ea, src;
    int n0;
    prep(m, r, rv);
    n0 = i_mem.reads;
    go(ctl);
    pc = 16'h0102;
    rr = rv;
    ea = rv;
    if (m >= 3'h6) begin
      ea = mw(pc);
      pc = pc + 16'h2;
      ea = ea + ((r == 3'h7) ? pc : rr);
    end else if (m == 3'h4 || m == 3'h5) begin
      rr = rr - 16'h2;
      ea = rr;
    end else if (r == 3'h7 && (m == 3'h2 || m == 3'h3)) begin
      ea = pc;
      pc = pc + 16'h2;
    end
    src = (m == 3'h0) ? rr : mw(ea);
    if (m[0] && m != 3'h1)
      src = mw(src);
    if ((m == 3'h2 || m == 3'h3) && r != 3'h7)
      rr = rr + 16'h2;
    if (r == 3'h7)
      rr = pc;
    rd(`OPDEC_SRC_OFS);
    check("source", {16'h0, src}, q);
    rd(ga(r));
    check("register", {16'h0, rr}, q);
    rd(ga(3'h7));
    check("pc", {16'h0, pc}, q);
    rd(`OPDEC_DEST_OFS);
    check("dest", 32'h0000beef, q);
    check("reads", n0 + 1 + extra[m], i_mem.reads);
    rd(`OPDEC_CTRL_OFS);
    check("ctrl", 32'h0, q);
    rd(`OPDEC_STATUS_OFS);
    check("traced", {31'h0, ctl[1]}, {31'h0, q[2]});
    wr(`OPDEC_CTRL_OFS, 32'h8);
    wait_idle();
    rd(`OPDEC_PURE_OFS);
    check("pure", {16'h0, src}, q);
    rd(ga(r));
    check("register kept", {16'h0, rr}, q);
  endtask

  task automatic t_regs();
    rd(`OPDEC_CTRL_OFS);
    check("ctrl reset", 32'h0, q);
    rd(`OPDEC_STATUS_OFS);
    check("status reset", 32'h0, q);
    rd(8'h1c);
    check("unmapped", 32'h1, {q[30:0], e});
    $display("t_regs done");
  endtask

  task automatic t_modes();
    run_one(3'h0, 3'h1, 16'h0200, 32'h1);
    run_one(3'h1, 3'h1, 16'h0200, 32'h1);
    run_one(3'h2, 3'h1, 16'h0200, 32'h1);
    run_one(3'h2, 3'h7, 16'h0100, 32'h1);
    run_one(3'h3, 3'h1, 16'h0200, 32'h1);
    run_one(3'h3, 3'h7, 16'h0100, 32'h1);
    run_one(3'h4, 3'h1, 16'h0200, 32'h1);
    run_one(3'h5, 3'h1, 16'h0200, 32'h1);
    run_one(3'h6, 3'h1, 16'h0200, 32'h1);
    run_one(3'h6, 3'h7, 16'h0100, 32'h1);
    run_one(3'h7, 3'h7, 16'h0100, 32'h1);
    lat = 2'h3;
    run_one(3'h7, 3'h1, 16'h0200, 32'h1);
    lat = 2'h0;
    $display("t_modes done");
  endtask

  // SP ending at 0x100 is legal, at 0xfe it overflows
  task automatic t_stack();
    run_one(3'h4, 3'h6, 16'h0102, 32'h1);
    rd(`OPDEC_STATUS_OFS);
    check("stack ok", 32'h0, {31'h0, q[1]});
    run_one(3'h5, 3'h6, 16'h0100, 32'h1);
    rd(`OPDEC_STATUS_OFS);
    check("stack over", 32'h1, {31'h0, q[1]});
    wr(`OPDEC_STATUS_OFS, 32'h2);
    rd(`OPDEC_STATUS_OFS);
    check("stack clear", 32'h0, {31'h0, q[1]});
    $display("t_stack done");
  endtask

  task automatic t_trace();
    lat = 2'h3;
    run_one(3'h0, 3'h1, 16'h1234, 32'h3);
    rd(`OPDEC_VECTOR_OFS);
    check("vector", 32'h0000000c, q);
    wr(`OPDEC_STATUS_OFS, 32'h4);
    lat = 2'h0;
    $display("t_trace done");
  endtask

  task automatic t_irq();
    int n0;
    prep(3'h0, 3'h1, 16'h0000);
    n0 = i_mem.reads;
    wr(`OPDEC_CTRL_OFS, 32'h5);
    repeat (20) @(posedge clk);
    check("blocked reads", n0, i_mem.reads);
    rd(ga(3'h7));
    check("blocked pc", 32'h00000100, q);
    wr(`OPDEC_CTRL_OFS, 32'h0);
    $display("t_irq done");
  endtask

  task automatic t_odd();
    prep(3'h1, 3'h1, 16'h0201);
    go(32'h1);
    rd(`OPDEC_STATUS_OFS);
    check("boundary", 32'h1, {31'h0, q[0]});
    wr(`OPDEC_STATUS_OFS, 32'h1);
    $display("t_odd done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_modes();
    t_stack();
    t_trace();
    t_irq();
    t_odd();
    test_done();
  end
endmodule // operand_address_decode_tb

`default_nettype wire
